// >>> src/spgs_pkg.sv
// Package: register map, field layout and carriers of the status pin block
package spgs_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] SPGS_OFF_PIN_CFG  = 8'h00;
  localparam logic [7:0] SPGS_OFF_STARTUP  = 8'h04;
  localparam logic [7:0] SPGS_OFF_PIN_STS  = 8'h08;
  localparam logic [7:0] SPGS_OFF_SPARE    = 8'h0C;
  localparam logic [7:0] SPGS_OFF_OE_CFG   = 8'h10;
  localparam logic [7:0] SPGS_OFF_IRQ_STS  = 8'h14;
  localparam logic [7:0] SPGS_OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] SPGS_OFF_DEV_CTL  = 8'h1C;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int SPGS_B_OD  = 12;
  localparam int SPGS_B_HIZ = 11;
  localparam int SPGS_B_PD  = 10;
  localparam int SPGS_B_PU  = 9;
  localparam int SPGS_B_POL = 8;
  localparam int SPGS_B_BOND = 7;
  localparam int SPGS_B_RB_PIN = 1;
  localparam int SPGS_B_RB_OE  = 0;
  localparam logic [31:0] SPGS_CFG_WMASK   = 32'h0000_1F1F;
  localparam logic [31:0] SPGS_CFG_RST     = 32'h0000_0200;
  localparam logic [31:0] SPGS_SPARE_RST   = 32'h0000_0000;
  localparam logic [31:0] SPGS_OE_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] SPGS_DEV_CTL_RST = 32'h0000_0000;
  localparam logic [31:0] SPGS_IRQ_RST     = 32'h0000_0000;
  localparam int SPGS_NIRQ = 3;

  // ****************************************************************
  // Source selector codes
  // ****************************************************************
  localparam logic [4:0] SPGS_SEL_APLL  = 5'h00;
  localparam logic [4:0] SPGS_SEL_DPLL  = 5'h01;
  localparam logic [4:0] SPGS_SEL_LOS0  = 5'h02;
  localparam logic [4:0] SPGS_SEL_LOS1  = 5'h03;
  localparam logic [4:0] SPGS_SEL_LOSX  = 5'h04;
  localparam logic [4:0] SPGS_SEL_ACT0  = 5'h05;
  localparam logic [4:0] SPGS_SEL_ACT1  = 5'h06;
  localparam logic [4:0] SPGS_SEL_INV0  = 5'h07;
  localparam logic [4:0] SPGS_SEL_INV1  = 5'h08;
  localparam logic [4:0] SPGS_SEL_IRQ   = 5'h09;
  localparam logic [4:0] SPGS_SEL_READY = 5'h0A;
  localparam logic [4:0] SPGS_SEL_LOW   = 5'h1D;
  localparam logic [4:0] SPGS_SEL_HIGH  = 5'h1E;
  localparam logic [4:0] SPGS_SEL_NOPOL = 5'h1F;

  localparam logic [1:0] SPGS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SPGS_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic apll_lock;
    logic dpll_lock;
    logic loss_monitor_ref0;
    logic loss_monitor_ref1;
    logic loss_monitor_xtal;
    logic activity_monitor_ref0;
    logic activity_monitor_ref1;
    logic ref0_invalid;
    logic ref1_invalid;
    logic device_irq;
    logic device_ready;
  } spgs_src_t;

  typedef struct packed {
    logic o;
    logic oe;
    logic pu_on;
    logic pd_on;
  } spgs_pin_t;

endpackage : spgs_pkg

// >>> src/spgs_pin_drv.sv
// Status pin source mux, polarity and output stage
module spgs_pin_drv
  import spgs_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire spgs_pkg::spgs_src_t src,
  input  wire logic [4:0]        sel,
  input  wire logic              pol,
  input  wire logic              open_drain,
  input  wire logic              hiz,
  input  wire logic              pd_en,
  input  wire logic              pu_en,
  output spgs_pkg::spgs_pin_t    pin,
  output logic                   readback
);

  typedef struct packed {
    spgs_pin_t pin;
    logic      rb;
  } spgs_drv_st_t;

  spgs_drv_st_t st_q;
  spgs_drv_st_t st_d;
  logic         raw;
  logic         val;

  always_comb
  begin
    case (sel)
      SPGS_SEL_APLL:  raw = src.apll_lock; // [RQ8]
      SPGS_SEL_DPLL:  raw = src.dpll_lock; // [RQ8]
      SPGS_SEL_LOS0:  raw = src.loss_monitor_ref0; // [RQ8]
      SPGS_SEL_LOS1:  raw = src.loss_monitor_ref1; // [RQ8]
      SPGS_SEL_LOSX:  raw = src.loss_monitor_xtal; // [RQ8]
      SPGS_SEL_ACT0:  raw = src.activity_monitor_ref0; // [RQ9]
      SPGS_SEL_ACT1:  raw = src.activity_monitor_ref1; // [RQ9]
      SPGS_SEL_INV0:  raw = src.ref0_invalid; // [RQ9]
      SPGS_SEL_INV1:  raw = src.ref1_invalid; // [RQ9]
      SPGS_SEL_IRQ:   raw = src.device_irq; // [RQ10]
      SPGS_SEL_READY: raw = src.device_ready; // [RQ11]
      SPGS_SEL_HIGH:  raw = 1'b1; // [RQ12]
      default:        raw = 1'b0; // [RQ12]
    endcase
  end

  always_comb
  begin
    // Code 0x1F drives the raw value whatever the polarity in push-pull mode
    val = (pol && sel != SPGS_SEL_NOPOL) ? ~raw : raw; // [RQ6] [RQ7]
    st_d = st_q;
    st_d.pin.pu_on = pu_en; // [RQ5]
    st_d.pin.pd_on = pd_en; // [RQ4]
    if (hiz)
    begin
      st_d.pin.o  = 1'b0;
      st_d.pin.oe = 1'b0; // [RQ3]
    end
    else if (open_drain)
    begin
      // Value to output is the pre-polarity signal; pol picks sink sense
      st_d.pin.o  = 1'b0;
      st_d.pin.oe = pol ? raw : ~raw; // [RQ1] [RQ2]
    end
    else
    begin
      st_d.pin.o  = val;
      st_d.pin.oe = 1'b1;
    end
    st_d.rb = (sel <= SPGS_SEL_LOSX) ? val : 1'b0; // [RQ15]
    if (!aresetn)
    begin
      st_d = '0;
      st_d.pin.pu_on = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    st_q <= st_d;
  end

  assign pin      = st_q.pin;
  assign readback = st_q.rb;

endmodule : spgs_pin_drv

// >>> src/spgs_top.sv
// Status pin and pin status block with AXI4-Lite register access
//
// What this block does
// [RQ1] Open-drain, polarity off: sink low for value 0, release for 1.
// [RQ2] Open-drain, polarity on: sink low for value 1, release for 0.
// [RQ3] Tristate bit set places the status pin in high impedance.
// [RQ4] Pull-down bit enables internal pull-down; avoid with open-drain.
// [RQ5] Pull-up bit enables weak internal pull-up; resets to one.
// [RQ6] Polarity bit: 0 drives true source value, 1 drives inverse.
// [RQ7] Polarity is ignored when the selector holds 0x1F, in push-pull mode only; open-drain still uses pol for the sink sense.
// [RQ8] Selector 0x0..0x4: APLL lock, DPLL lock, loss flags ref0/ref1/xtal.
// [RQ9] Selector 0x5/0x6 activity status, 0x7/0x8 reference-invalid status.
// [RQ10] Selector 0x9 drives interrupt flags ANDed with their mask.
// [RQ11] Selector 0xA drives ready once startup has completed.
// [RQ12] Selector 0x1D forces low, 0x1E high; others reserved.
// [RQ13] Six-bit read-only field holds pin levels captured at startup.
// [RQ14] Top startup status bit shows the bond option pad level.
// [RQ15] Status readback shows driven value for selector 0..4, else 0.
// [RQ16] Enable readback shows enable pin when bypass is 0, else 0.
// [RQ17] Thirty-two bit scratch word, read/write, no hardware effect.
// [RQ18] Bypass 0: deasserted enable pin disables outputs, not in SPI mode.
// [RQ19] Startup capture taken once at reset end, held until next reset.
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
module spgs_top
  import spgs_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire spgs_pkg::spgs_src_t src,
  input  wire logic                status_pin_i,
  output logic                     status_pin_o,
  output logic                     status_pin_oe,
  output logic                     status_pin_pullup,
  output logic                     status_pin_pulldown,
  input  wire logic                sda_pin_i,
  input  wire logic                scl_pin_i,
  input  wire logic                enable_or_select_pin,
  input  wire logic                bonding_option_bit,
  input  wire logic                spi_mode,
  output logic                     clk_out_enable,
  output logic                     irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0] pin_cfg;
    logic [31:0] spare_word;
    logic [31:0] oe_cfg;
    logic [31:0] dev_ctl;
    logic [SPGS_NIRQ-1:0] irq_sts;
    logic [SPGS_NIRQ-1:0] irq_mask;
    logic [5:0]  pins_latched_at_boot;
    logic        boot_done;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        ready_q;
    logic        enable_pin_q;
    logic        clk_en;
    logic        irq;
  } spgs_st_t;

  spgs_st_t        st_q;
  spgs_st_t        st_d;
  spgs_pin_t       pin;
  logic            readback;
  spgs_src_t       src_m;
  logic            oe_level;
  logic [SPGS_NIRQ-1:0] ev;
  logic            wr_go;
  logic            rd_go;
  logic [31:0]     wmask;

  // ****************************************************************
  // Source map and pin driver
  // ****************************************************************
  always_comb
  begin
    src_m = src;
    src_m.device_irq = st_q.irq; // [RQ10]
  end

  spgs_pin_drv u_drv (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .src        (src_m),
    .sel        (st_q.pin_cfg[4:0]),
    .pol        (st_q.pin_cfg[SPGS_B_POL]),
    .open_drain (st_q.pin_cfg[SPGS_B_OD]),
    .hiz        (st_q.pin_cfg[SPGS_B_HIZ]),
    .pd_en      (st_q.pin_cfg[SPGS_B_PD]),
    .pu_en      (st_q.pin_cfg[SPGS_B_PU]),
    .pin        (pin),
    .readback   (readback)
  );

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************
  assign s_axi_awready = !st_q.aw_held;
  assign s_axi_wready  = !st_q.w_held;
  assign s_axi_arready = !st_q.rvalid;
  assign wr_go = st_q.aw_held && st_q.w_held && !st_q.bvalid;
  assign rd_go = s_axi_arvalid && !st_q.rvalid;
  assign wmask = {{8{st_q.w_strb[3]}}, {8{st_q.w_strb[2]}},
                  {8{st_q.w_strb[1]}}, {8{st_q.w_strb[0]}}};

  // Pin polarity: sel=0 path is active high unless oe polarity bit set
  assign oe_level = st_q.enable_pin_q ^ st_q.oe_cfg[3];

  always_comb
  begin
    // Events: loss of APLL lock and loss of ref0 and xtal, level style, set on every cycle the condition holds
    ev = {src.loss_monitor_xtal, src.loss_monitor_ref0, ~src.apll_lock};
    st_d = st_q;
    st_d.enable_pin_q = enable_or_select_pin;
    st_d.ready_q = src.device_ready;
    // Capture only on the first cycle after reset release
    if (!st_q.boot_done)
    begin
      st_d.boot_done = 1'b1;
      st_d.pins_latched_at_boot = {2'b00, enable_or_select_pin,
                                   scl_pin_i, sda_pin_i,
                                   status_pin_i}; // [RQ13] [RQ19]
    end
    // Hardware set wins over a clearing read
    st_d.irq_sts = st_q.irq_sts | ev;
    st_d.irq = |(st_q.irq_sts & st_q.irq_mask);
    st_d.clk_en = (st_q.oe_cfg[0] || spi_mode) ? 1'b1 : oe_level; // [RQ18]

    if (s_axi_awvalid && !st_q.aw_held)
    begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_held)
    begin
      st_d.w_held = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (wr_go)
    begin
      st_d.aw_held = 1'b0;
      st_d.w_held = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = SPGS_RESP_OKAY;
      case (st_q.aw_addr & 8'hFC)
        SPGS_OFF_PIN_CFG:
          st_d.pin_cfg = (st_q.pin_cfg & ~(wmask & SPGS_CFG_WMASK)) |
                         (st_q.w_data & wmask & SPGS_CFG_WMASK);
        SPGS_OFF_SPARE:
          st_d.spare_word = (st_q.spare_word & ~wmask) |
                            (st_q.w_data & wmask); // [RQ17]
        SPGS_OFF_OE_CFG:
          st_d.oe_cfg = (st_q.oe_cfg & ~wmask) | (st_q.w_data & wmask);
        SPGS_OFF_IRQ_MASK:
          st_d.irq_mask = st_q.w_data[SPGS_NIRQ-1:0];
        SPGS_OFF_DEV_CTL:
          st_d.dev_ctl = (st_q.dev_ctl & ~wmask) | (st_q.w_data & wmask);
        SPGS_OFF_STARTUP, SPGS_OFF_PIN_STS, SPGS_OFF_IRQ_STS:
          st_d.bresp = SPGS_RESP_OKAY;
        default:
          st_d.bresp = SPGS_RESP_SLVERR;
      endcase
    end
    if (st_q.bvalid && s_axi_bready)
    begin
      st_d.bvalid = 1'b0;
    end

    if (rd_go)
    begin
      st_d.rvalid = 1'b1;
      st_d.rresp = SPGS_RESP_OKAY;
      st_d.rdata = '0;
      case (s_axi_araddr & 8'hFC)
        SPGS_OFF_PIN_CFG:
          st_d.rdata = st_q.pin_cfg;
        SPGS_OFF_STARTUP:
        begin
          st_d.rdata[5:0] = st_q.pins_latched_at_boot; // [RQ13]
          st_d.rdata[SPGS_B_BOND] = bonding_option_bit; // [RQ14]
        end
        SPGS_OFF_PIN_STS:
        begin
          st_d.rdata[SPGS_B_RB_PIN] = readback; // [RQ15]
          st_d.rdata[SPGS_B_RB_OE] = st_q.oe_cfg[0] ? 1'b0 :
                                     st_q.enable_pin_q; // [RQ16]
        end
        SPGS_OFF_SPARE:
          st_d.rdata = st_q.spare_word; // [RQ17]
        SPGS_OFF_OE_CFG:
          st_d.rdata = st_q.oe_cfg;
        SPGS_OFF_IRQ_STS:
        begin
          st_d.rdata[SPGS_NIRQ-1:0] = st_q.irq_sts;
          st_d.irq_sts = ev; // Read clears, events this cycle survive
        end
        SPGS_OFF_IRQ_MASK:
          st_d.rdata[SPGS_NIRQ-1:0] = st_q.irq_mask;
        SPGS_OFF_DEV_CTL:
          st_d.rdata = st_q.dev_ctl;
        default:
          st_d.rresp = SPGS_RESP_SLVERR;
      endcase
    end
    else if (st_q.rvalid && s_axi_rready)
    begin
      st_d.rvalid = 1'b0;
    end

    if (!aresetn)
    begin
      st_d = '0;
      st_d.pin_cfg = SPGS_CFG_RST; // [RQ5]
      st_d.spare_word = SPGS_SPARE_RST; // [RQ17]
      st_d.oe_cfg = SPGS_OE_CFG_RST;
      st_d.dev_ctl = SPGS_DEV_CTL_RST;
      st_d.irq_sts = SPGS_IRQ_RST[SPGS_NIRQ-1:0];
      st_d.clk_en = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    st_q <= st_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_bvalid        = st_q.bvalid;
  assign s_axi_bresp         = st_q.bresp;
  assign s_axi_rvalid        = st_q.rvalid;
  assign s_axi_rdata         = st_q.rdata;
  assign s_axi_rresp         = st_q.rresp;
  assign status_pin_o        = pin.o;
  assign status_pin_oe       = pin.oe;
  assign status_pin_pullup   = pin.pu_on;
  assign status_pin_pulldown = pin.pd_on;
  assign clk_out_enable      = st_q.clk_en;
  assign irq                 = st_q.irq;

endmodule : spgs_top

// >>> bench/spgs_asserts.sv
// Concurrent checks on the ports of the status pin block
module spgs_asserts
  import spgs_pkg::*;
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic [7:0]         s_axi_awaddr,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic [31:0]        s_axi_wdata,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire spgs_pkg::spgs_src_t src,
  input wire logic               status_pin_o,
  input wire logic               status_pin_oe,
  input wire logic               status_pin_pullup,
  input wire logic               status_pin_pulldown,
  input wire logic               enable_or_select_pin,
  input wire logic               spi_mode,
  input wire logic               clk_out_enable
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Shadow of written config, one edge behind the register
  // ****************************************************************
  logic [7:0]  a_q;
  logic [31:0] d_q;
  logic [31:0] cfg_q;
  logic [31:0] oec_q;
  logic [10:0] src_q;
  logic        b_q;
  logic        ok_q;
  logic        ok2_q;
  logic        kn;
  logic        v;

  // Full strobes assumed: the bench never writes partial words
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      a_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
      d_q <= s_axi_wdata;
    b_q   <= s_axi_bvalid;
    src_q <= src;
    ok_q  <= aresetn;
    ok2_q <= ok_q && aresetn;
    if (!aresetn)
      cfg_q <= SPGS_CFG_RST;
    else if (s_axi_bvalid && !b_q && a_q == SPGS_OFF_PIN_CFG)
      cfg_q <= d_q & SPGS_CFG_WMASK;
    if (!aresetn)
      oec_q <= SPGS_OE_CFG_RST;
    else if (s_axi_bvalid && !b_q && a_q == SPGS_OFF_OE_CFG)
      oec_q <= d_q;
  end

  assign kn = cfg_q[4:0] <= 5'h08 || cfg_q[4:0] == SPGS_SEL_READY;
  assign v  = src_q[4'd10 - cfg_q[3:0]];

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence

  write_resp_a: assert property (wr_both |=> wr_answer)
    else $error("write response late");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  pin_hiz_a: assert property (ok2_q && cfg_q[SPGS_B_HIZ] |-> !status_pin_oe)
    else $error("pin driven in high impedance");
  pin_pulls_a: assert property (ok2_q |->
    status_pin_pullup == cfg_q[SPGS_B_PU]
    && status_pin_pulldown == cfg_q[SPGS_B_PD]) else $error("pulls wrong");
  push_value_a: assert property (ok2_q && kn && cfg_q[12:11] == 2'b00
    |-> status_pin_oe && status_pin_o == (v ^ cfg_q[SPGS_B_POL]))
    else $error("driven value wrong");
  open_drain_a: assert property (ok2_q && kn && cfg_q[12:11] == 2'b10
    |-> status_pin_oe == (v == cfg_q[SPGS_B_POL])
    && !(status_pin_oe && status_pin_o)) else $error("open drain wrong");
  clk_gate_a: assert property (ok2_q && !oec_q[0] |-> clk_out_enable ==
    ($past(spi_mode) || ($past(enable_or_select_pin, 2) ^ oec_q[3])))
    else $error("clock enable wrong");
  clk_bypass_a: assert property (ok2_q && oec_q[0] |-> clk_out_enable)
    else $error("clock enable not bypassed");
endmodule : spgs_asserts

// >>> bench/spgs_board.sv
// Board side of the status pin: resolves the wire level
module spgs_board
(
  input  wire logic aclk,
  input  wire logic o,
  input  wire logic oe,
  input  wire logic pull_up_on,
  input  wire logic pull_down_on,
  output logic      level
);
  timeunit 1ns;
  timeprecision 100ps;

  // A floating wire wanders, so show the inverse of the last level
  always @(posedge aclk)
    level <= oe ? o : pull_up_on ? 1'b1 : pull_down_on ? 1'b0 : !level;
endmodule : spgs_board

// >>> bench/spgs_bench.sv
// Self-checking bench of the status pin block
module spgs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import spgs_pkg::*;

  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, status_pin_i;
  logic        status_pin_o, status_pin_oe, status_pin_pullup, irq;
  logic        status_pin_pulldown, sda_pin_i, scl_pin_i, spi_mode;
  logic        enable_or_select_pin, bonding_option_bit, clk_out_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, p, v;
  logic [4:0]  s;
  spgs_src_t   src;
  int          fails, cmp_count;

  spgs_top u_spgs_top (.*);
  spgs_board u_spgs_board (.aclk(aclk), .o(status_pin_o),
    .oe(status_pin_oe), .pull_up_on(status_pin_pullup),
    .pull_down_on(status_pin_pulldown), .level(status_pin_i));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = !aclk;
  end

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic conclude;
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic seen(input string n, ref logic g, input logic e);
    @(negedge aclk);
    chk(n, 32'(e), 32'(g));
  endtask : seen

  task automatic pin(input logic eoe, input logic eo);
    seen("pin_oe", status_pin_oe, eoe);
    if (eoe)
      chk("pin_o", 32'(eo), 32'(status_pin_o));
  endtask : pin

  // bready is raised with awvalid and wvalid, before bvalid shows, so response holding is not exercised
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = SPGS_RESP_OKAY);
    int   n;
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50 && !hb; n++)
    begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      if (hb)
        chk("bresp", 32'(r), 32'(s_axi_bresp));
      @(posedge aclk);
      if (ha)
        s_axi_awvalid <= 1'b0;
      if (hw)
        s_axi_wvalid <= 1'b0;
      if (hb)
        s_axi_bready <= 1'b0;
    end
    if (!hb)
    begin
      fails++;
      conclude();
    end
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] e,
                     input string m, input logic [1:0] r = SPGS_RESP_OKAY);
    int   n;
    logic ha, hb;
    hb = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50 && !hb; n++)
    begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hb = s_axi_rvalid;
      if (hb)
      begin
        chk("rresp", 32'(r), 32'(s_axi_rresp));
        if (r == SPGS_RESP_OKAY)
          chk(m, e, s_axi_rdata);
      end
      @(posedge aclk);
      if (ha)
        s_axi_arvalid <= 1'b0;
      if (hb)
        s_axi_rready <= 1'b0;
    end
    if (!hb)
    begin
      fails++;
      conclude();
    end
  endtask : axr

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    fails = 0;
    cmp_count = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
     s_axi_rready, scl_pin_i, spi_mode, s_axi_awaddr, s_axi_araddr,
     s_axi_wdata, src} <= '0;
    {sda_pin_i, enable_or_select_pin, bonding_option_bit} <= 3'b111;
    s_axi_wstrb <= 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axr(SPGS_OFF_PIN_CFG, SPGS_CFG_RST, "cfg");
    axr(SPGS_OFF_SPARE, 32'h0000_0000, "spare");
    axr(SPGS_OFF_STARTUP, 32'h0000_008B, "boot");
    sda_pin_i <= 1'b0;
    axw(SPGS_OFF_STARTUP, 32'h0000_0000);
    axr(SPGS_OFF_STARTUP, 32'h0000_008B, "boot");
    bonding_option_bit <= 1'b0;
    axr(SPGS_OFF_STARTUP, 32'h0000_000B, "bond");
    axw(SPGS_OFF_SPARE, 32'hA5A5_5A5A);
    axr(SPGS_OFF_SPARE, 32'hA5A5_5A5A, "spare");
    axw(8'h20, 32'h0000_0001, SPGS_RESP_SLVERR);
    axr(8'h20, 32'h0000_0000, "unmapped", SPGS_RESP_SLVERR);
    // Unlocked analog loop raises event bit 0 while still masked
    seen("irq", irq, 1'b0);
    axw(SPGS_OFF_IRQ_MASK, 32'h0000_0001);
    seen("irq", irq, 1'b1);
    axw(SPGS_OFF_PIN_CFG, 32'h0000_0209);
    pin(1'b1, 1'b1);
    @(posedge aclk);
    src.apll_lock <= 1'b1;
    axr(SPGS_OFF_IRQ_STS, 32'h0000_0001, "irq_sts");
    axr(SPGS_OFF_IRQ_STS, 32'h0000_0000, "irq_sts");
    pin(1'b1, 1'b0);
    for (s = 0; s < 11; s++)
      for (p = 0; p < 2; p++)
        for (v = 0; v < 2; v++)
          if (s != 5'd9)
          begin
            @(posedge aclk);
            src <= spgs_src_t'(v[0] ? 11'h400 >> s : ~(11'h400 >> s));
            axw(SPGS_OFF_PIN_CFG, {23'h1, p[0], 3'h0, s});
            pin(1'b1, v[0] ^ p[0]);
            axr(SPGS_OFF_PIN_STS, {30'h0, s < 5 && (v[0] ^ p[0]), 1'b1},
                "readback");
          end
    axw(SPGS_OFF_PIN_CFG, 32'h0000_021D);
    pin(1'b1, 1'b0);
    axw(SPGS_OFF_PIN_CFG, 32'h0000_021E);
    pin(1'b1, 1'b1);
    axw(SPGS_OFF_PIN_CFG, 32'h0000_031F);
    pin(1'b1, 1'b0);
    for (p = 0; p < 2; p++)
      for (v = 0; v < 2; v++)
      begin
        @(posedge aclk);
        src <= spgs_src_t'({v[0], 10'h0});
        axw(SPGS_OFF_PIN_CFG, {19'h0, 4'h8, p[0], 8'h0});
        pin(v == p, 1'b0);
      end
    axw(SPGS_OFF_PIN_CFG, 32'h0000_0C1E);
    pin(1'b0, 1'b0);
    chk("pulls", 32'h1, {30'h0, status_pin_pullup, status_pin_pulldown});
    @(posedge aclk);
    enable_or_select_pin <= 1'b0;
    axr(SPGS_OFF_PIN_STS, 32'h0000_0000, "readback");
    seen("clk_en", clk_out_enable, 1'b0);
    @(posedge aclk);
    spi_mode <= 1'b1;
    axw(SPGS_OFF_OE_CFG, 32'h0000_0008);
    seen("clk_en", clk_out_enable, 1'b1);
    @(posedge aclk);
    spi_mode <= 1'b0;
    enable_or_select_pin <= 1'b1;
    axr(SPGS_OFF_PIN_STS, 32'h0000_0001, "readback");
    seen("clk_en", clk_out_enable, 1'b0);
    axw(SPGS_OFF_OE_CFG, 32'h0000_0009);
    seen("clk_en", clk_out_enable, 1'b1);
    axr(SPGS_OFF_PIN_STS, 32'h0000_0000, "readback");
    conclude();
  end
endmodule : spgs_bench

bind spgs_top spgs_asserts u_spgs_asserts (.*);
